// [bench/driver_side_model.sv]
// Driver side: open-drain power-good line and core low-side state.
// Assumes a pull-up on the power-good line.
module driver_side_model (
    input  logic pg_out, pg_oe, drv_en, pwm_oe, pwm,
    output logic pg_line, ls_on
);
    timeunit 1ns / 1ps;
    // Released line shows the pull-up, never a stale level
    assign pg_line = pg_oe ? pg_out : 1'b1;
    // Low side on: driver on, PWM driven low
    assign ls_on = drv_en && pwm_oe && !pwm;
endmodule // driver_side_model

// [bench/rail_fault_supervisor_asserts.sv]
// Pin-level checker of the fault supervisor.
// Assumes pins settle within five clocks.
module rail_fault_supervisor_asserts #(
    parameter CORE_PHASES = 4
) (
    input logic aclk, aresetn, enable_pin, voltage_transition, core_ov_cmp, core_uv_cmp,
    input logic ref_above_500mv_cmp, core_oc_avg_cmp, soft_start_done, core_first_pulse,
    input logic core_driver_enable, osc_fault_pin, power_good_oe,
    input logic [CORE_PHASES-1:0] core_phase_pwm_out
);
    timeunit 1ns / 1ps;
    logic [4:0] run_q;
    logic       seen_q;
    // Enabled, no transition; saturates past re-arm
    always @(posedge aclk)
        if (!aresetn || !enable_pin || voltage_transition)
            run_q <= 5'h00;
        else if (run_q != 5'h1f)
            run_q <= run_q + 5'h01;
    // Pulse seen
    always @(posedge aclk)
        seen_q <= aresetn && (seen_q || core_first_pulse);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ov_clamp_a: assert property (((&run_q) && core_ov_cmp)[*5] |=>
        core_driver_enable && core_phase_pwm_out == '0) else $error("no clamp");
    ov_flag_a: assert property (((&run_q) && core_ov_cmp)[*5] |=> osc_fault_pin)
        else $error("no fault pin");
    uv_trip_a: assert property (((&run_q) && core_uv_cmp && ref_above_500mv_cmp)[*5]
        |=> osc_fault_pin) else $error("no uv trip");
    oc_unmasked_a: assert property ((enable_pin && core_oc_avg_cmp)[*5] |=> osc_fault_pin)
        else $error("oc missed");
    latch_hold_a: assert property (enable_pin[*6] ##0 osc_fault_pin |=> osc_fault_pin)
        else $error("latch dropped");
    enable_clear_a: assert property ((!enable_pin)[*6] |-> !osc_fault_pin)
        else $error("latch kept");
    pg_start_a: assert property ((!soft_start_done)[*3] |-> power_good_oe)
        else $error("pg early");
    start_hiz_a: assert property (!seen_q && !osc_fault_pin |-> !core_driver_enable)
        else $error("driver on early");
endmodule // rail_fault_supervisor_asserts

bind rail_fault_supervisor rail_fault_supervisor_asserts #(.CORE_PHASES(CORE_PHASES)) u_chk (.*);

// [bench/rail_fault_supervisor_tb.sv]
// Bench: AXI4-Lite tasks, comparator stimulus, pin checks.
// Assumes the supervisor, its header and the driver model.
`include "rail_fault_defines.vh"
module rail_fault_supervisor_tb;
    timeunit 1ns / 1ps;
    logic aclk = 0, aresetn = 0, enable_pin = 1, bus_disable_strap = 0, voltage_transition = 0;
    logic soft_start_done = 0, core_first_pulse = 0, aux_first_pulse = 0, aux_pwm_in = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, core_driver_enable, aux_phase_pwm_out, aux_phase_pwm_oe;
    logic aux_driver_enable, osc_fault_pin, power_good_out, power_good_oe, pg_line, ls_on;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ov_thresh_sel;
    logic [3:0]  core_pwm_in = 4'h5, s_axi_wstrb = 4'hf, core_phase_pwm_out, core_phase_pwm_oe;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [9:0]  ov_offset_mv;
    logic [13:0] c = 14'h2000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    int failures = 0, compares = 0, cyc = 0;
    wire core_ov_cmp = c[0], aux_ov_cmp = c[1], core_uv_cmp = c[2], aux_uv_cmp = c[3];
    wire core_below_good_cmp = c[4], aux_below_good_cmp = c[5], core_sense_disc_cmp = c[6];
    wire aux_sense_disc_cmp = c[7], core_ground_sense_cmp = c[8], aux_ground_sense_cmp = c[9];
    wire core_oc_phase_cmp = c[10], core_oc_avg_cmp = c[11], aux_oc_cmp = c[12];
    wire ref_above_500mv_cmp = c[13];

    rail_fault_supervisor #(.ADDR_W(5)) u_rail_fault_supervisor (.*);
    driver_side_model u_driver_side_model (.pg_out(power_good_out), .pg_oe(power_good_oe),
        .drv_en(core_driver_enable), .pwm_oe(core_phase_pwm_oe[0]),
        .pwm(core_phase_pwm_out[0]), .pg_line(pg_line), .ls_on(ls_on));

    always #5 aclk = ~aclk;
    // Hang guard
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Address and data offered together
    task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            if (ad) s_axi_awvalid <= 0;
            if (wd) s_axi_wvalid <= 0;
        end while (!(ad && wd));
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    task rdk(input logic [4:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    // Enable cycle restarts a latch
    task recycle;
        @(posedge aclk);
        enable_pin <= 0;
        tick(8);
        enable_pin <= 1;
        tick(8);
    endtask

    initial
    begin
        tick(5);
        aresetn <= 1;
        tick(4);
        chk({core_driver_enable, pg_line}, 2'h0);
        rdk(5'h08, `RESP_OKAY);
        chk(rd, 32'h0fa);
        wr(5'h08, 32'h120, `RESP_OKAY);
        rdk(5'h10, `RESP_SLVERR);
        bus_disable_strap <= 1;
        wr(5'h10, 32'h0, `RESP_SLVERR);
        chk({ov_offset_mv, ov_thresh_sel}, {10'h120, `OVSEL_PIN});
        bus_disable_strap <= 0;
        wr(5'h00, `MODE_FIXED, `RESP_OKAY);
        tick(2);
        chk(ov_thresh_sel, `OVSEL_FIXED_1V8);
        wr(5'h00, `MODE_SERIAL, `RESP_OKAY);
        {core_first_pulse, aux_first_pulse, soft_start_done, c[5]} <= 4'hf;
        tick(30);
        chk({core_driver_enable, pg_line, core_phase_pwm_out, aux_phase_pwm_out}, 7'h4b);
        wr(5'h00, `MODE_PARALLEL, `RESP_OKAY);
        tick(4);
        chk(pg_line, 1);
        voltage_transition <= 1;
        tick(2);
        c[4] <= 1;
        tick(8);
        chk(pg_line, 1);
        {c[5], c[4], voltage_transition} <= 3'h0;
        wr(5'h00, `MODE_SERIAL, `RESP_OKAY);
        tick(30);
        c[0] <= 1;
        tick(6);
        chk({ls_on, aux_driver_enable, aux_phase_pwm_oe, osc_fault_pin}, 4'h9);
        c[0] <= 0;
        wr(5'h0c, 32'h0, `RESP_OKAY);
        rdk(5'h0c, `RESP_OKAY);
        chk({rd[`FLT_CORE_OV], osc_fault_pin}, 2'h3);
        recycle();
        chk(osc_fault_pin, 0);
        {voltage_transition, c[2]} <= 2'h3;
        tick(10);
        voltage_transition <= 0;
        tick(12);
        chk(osc_fault_pin, 0);
        tick(16);
        chk({osc_fault_pin, core_phase_pwm_oe, aux_phase_pwm_oe}, 6'h20);
        c[13] <= 0;
        recycle();
        tick(8);
        chk(osc_fault_pin, 0);
        {c[13], c[2], soft_start_done} <= 3'h4;
        for (int i = 6; i < 13; i++)
        begin
            c[i] <= 1;
            voltage_transition <= (i > 9);
            tick(6);
            chk({osc_fault_pin, core_phase_pwm_oe}, 5'h10);
            c[i] <= 0;
            voltage_transition <= 0;
            recycle();
        end
        wr(5'h00, `MODE_PARALLEL, `RESP_OKAY);
        c[7] <= 1;
        tick(8);
        chk(osc_fault_pin, 0);
        give_verdict();
    end
endmodule // rail_fault_supervisor_tb

// [src/level_sync.v]
// Two-flop synchroniser for independent levels.
// Assumes slow levels; no coherence between bits.
module level_sync #(
    parameter W = 1
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // level_sync

// [src/rail_fault_defines.vh]
// Offsets, fields and timing counts of the rail fault supervisor.
// Definitions only.
`ifndef RAIL_FAULT_DEFINES_VH
`define RAIL_FAULT_DEFINES_VH

// Register byte offsets
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_OV_OFFSET   4'h8
`define ADDR_FAULT       4'hc

// Control register fields
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    1
`define CTRL_CORE_OFF    2
`define CTRL_RST         32'h0000_0001

// Operating modes
`define MODE_PARALLEL    2'h0
`define MODE_SERIAL      2'h1
`define MODE_FIXED       2'h2

// Overvoltage offset above reference, mV
`define OV_OFFSET_W      10
`define OV_OFFSET_RST    10'h0fa

// Overvoltage threshold source selects
`define OVSEL_REF_OFFSET 2'h0
`define OVSEL_FIXED_1V8  2'h1
`define OVSEL_PIN        2'h2

// Fault state bit positions
`define FLT_CORE_OV      0
`define FLT_AUX_OV       1
`define FLT_UV           2
`define FLT_CORE_SDISC   3
`define FLT_AUX_SDISC    4
`define FLT_CORE_GND     5
`define FLT_AUX_GND      6
`define FLT_CORE_OC      7
`define FLT_AUX_OC       8
`define FLT_W            9

// Status register fields
`define ST_RAIL_GOOD_FLAG         0
`define ST_CORE_GOOD     1
`define ST_AUX_GOOD      2
`define ST_PG_MASKED     3
`define ST_PROT_MASKED   4
`define ST_ENABLE        5
`define ST_STRAP         6
`define ST_CORE_STARTED  7
`define ST_AUX_STARTED   8

// Re-arm delay after a transition, in clocks
`define REARM_CYCLES     16

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [src/rail_fault_supervisor.v]
// Fault supervisor for a core rail and an auxiliary rail: latches
// comparator faults, drives PWM/driver-enable pins, fault and power good.
// Assumes analog comparator levels are asynchronous; soft-start, first
// pulse, PWM and transition signals come from logic on aclk.
// How it works
// - Rail overvoltage clamps its PWM low, driver enable high.
// - In serial mode, overvoltage also puts the other rail in high impedance.
// - Any overvoltage latch drives the oscillator/fault pin high.
// - OV threshold: reference plus offset, or fixed 1.8 V.
// - With the bus-disable strap high, threshold comes from the data pin.
// - Undervoltage trips at VID minus 400 mV, armed once reference passes 500 mV.
// - Undervoltage latches, tristates both rails and raises the fault pin.
// - Power good is core AND aux flags in serial mode, core alone otherwise.
// - Rail flag drops below reference minus 250 mV; rails keep switching.
// - Power good held low until soft-start completes.
// - Power good masked in transitions and, in serial mode only, while core is off, aux running.
// - Non-overcurrent protections masked in transitions, re-armed 16 clocks later.
// - Protections remain active during soft-start.
// - Core positive-sense disconnection latches high impedance and raises fault.
// - Core ground-sense loss over 500 mV, and aux in serial mode only, latches high impedance and raises fault.
// - Serial mode only, aux positive-sense disconnection latches likewise.
// - Core or aux overcurrent latches like undervoltage.
// - Rails stay tristated, driver enable low, until their first PWM pulse, except a rail under an overvoltage clamp.
`include "rail_fault_defines.vh"
module rail_fault_supervisor #(
    parameter CORE_PHASES = 4,
    parameter ADDR_W      = 4
) (
    input  wire                   aclk,
    input  wire                   aresetn,
    // AXI4-Lite slave
    input  wire [ADDR_W-1:0]      s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [ADDR_W-1:0]      s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    // Asynchronous pins and comparator levels
    input  wire                   enable_pin,
    input  wire                   bus_disable_strap,
    input  wire                   core_ov_cmp,
    input  wire                   aux_ov_cmp,
    input  wire                   core_uv_cmp,
    input  wire                   aux_uv_cmp,
    input  wire                   core_below_good_cmp,
    input  wire                   aux_below_good_cmp,
    input  wire                   core_sense_disc_cmp,
    input  wire                   aux_sense_disc_cmp,
    input  wire                   core_ground_sense_cmp,
    input  wire                   aux_ground_sense_cmp,
    input  wire                   core_oc_phase_cmp,
    input  wire                   core_oc_avg_cmp,
    input  wire                   aux_oc_cmp,
    input  wire                   ref_above_500mv_cmp,
    // On-chip control logic on aclk
    input  wire                   voltage_transition,
    input  wire                   soft_start_done,
    input  wire                   core_first_pulse,
    input  wire                   aux_first_pulse,
    input  wire [CORE_PHASES-1:0] core_pwm_in,
    input  wire                   aux_pwm_in,
    // Driver side
    output reg  [CORE_PHASES-1:0] core_phase_pwm_out,
    output reg  [CORE_PHASES-1:0] core_phase_pwm_oe,
    output reg                    core_driver_enable,
    output reg                    aux_phase_pwm_out,
    output reg                    aux_phase_pwm_oe,
    output reg                    aux_driver_enable,
    output reg                    osc_fault_pin,
    output reg                    power_good_out,
    output reg                    power_good_oe,
    // Threshold steering to the analog side
    output reg  [1:0]             ov_thresh_sel,
    output reg  [`OV_OFFSET_W-1:0] ov_offset_mv
);
    localparam SYNC_W = 16;

    // Rail drive states, one-hot
    localparam [2:0] RAIL_HIZ    = 3'b001;
    localparam [2:0] RAIL_SWITCH = 3'b010;
    localparam [2:0] RAIL_LOW    = 3'b100;

    // Overvoltage clamp beats any tristate request
    function [2:0] rail_state;
        input force_low;
        input hiz;
        begin
            if (force_low)
                rail_state = RAIL_LOW;
            else if (hiz)
                rail_state = RAIL_HIZ;
            else
                rail_state = RAIL_SWITCH;
        end
    endfunction

    // Shared decode; no aliasing above the map
    function [3:0] reg_hit;
        input [ADDR_W-1:0] addr;
        begin
            case (addr)
                `ADDR_CTRL:      reg_hit = 4'h1;
                `ADDR_STATUS:    reg_hit = 4'h2;
                `ADDR_OV_OFFSET: reg_hit = 4'h4;
                `ADDR_FAULT:     reg_hit = 4'h8;
                default:         reg_hit = 4'h0;
            endcase
        end
    endfunction

    // Byte-lane merge for writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction

    wire [SYNC_W-1:0] raw_in;
    wire [SYNC_W-1:0] sync_in;
    wire              prot_masked;

    assign raw_in = {enable_pin, bus_disable_strap, core_ov_cmp, aux_ov_cmp,
                     core_uv_cmp, aux_uv_cmp, core_below_good_cmp,
                     aux_below_good_cmp, core_sense_disc_cmp, aux_sense_disc_cmp,
                     core_ground_sense_cmp, aux_ground_sense_cmp,
                     core_oc_phase_cmp, core_oc_avg_cmp, aux_oc_cmp,
                     ref_above_500mv_cmp};

    level_sync #(
        .W (SYNC_W)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (raw_in),
        .q       (sync_in)
    );

    rearm_timer #(
        .CYCLES (`REARM_CYCLES)
    ) u_rearm (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .transition (voltage_transition),
        .masked     (prot_masked)
    );

    wire en_s        = sync_in[15];
    wire strap_s     = sync_in[14];
    wire core_ov_s   = sync_in[13];
    wire aux_ov_s    = sync_in[12];
    wire core_uv_s   = sync_in[11];
    wire aux_uv_s    = sync_in[10];
    wire core_low_s  = sync_in[9];
    wire aux_low_s   = sync_in[8];
    wire core_sd_s   = sync_in[7];
    wire aux_sd_s    = sync_in[6];
    wire core_gnd_s  = sync_in[5];
    wire aux_gnd_s   = sync_in[4];
    wire core_ocp_s  = sync_in[3];
    wire core_oca_s  = sync_in[2];
    wire aux_oc_s    = sync_in[1];
    wire ref_armed_s = sync_in[0];

    reg  [31:0]             ctrl_q;
    reg  [`OV_OFFSET_W-1:0] ov_offset_q;
    reg  [`FLT_W-1:0]       fault_q;
    reg                     core_started_q;
    reg                     aux_started_q;
    reg                     pg_q;
    reg                     aw_held_q;
    reg                     w_held_q;
    reg  [ADDR_W-1:0]       awaddr_q;
    reg  [31:0]             wdata_q;
    reg  [3:0]              wstrb_q;

    wire [1:0] mode     = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire       serial   = (mode == `MODE_SERIAL);
    wire       core_off = ctrl_q[`CTRL_CORE_OFF];

    // Fault sources; overcurrent ignores the transition mask
    reg [`FLT_W-1:0] fault_set;
    always @*
    begin
        fault_set = {`FLT_W{1'b0}};
        fault_set[`FLT_CORE_OV]    = core_ov_s & ~prot_masked;
        fault_set[`FLT_AUX_OV]     = aux_ov_s & ~prot_masked;
        fault_set[`FLT_UV]         = (core_uv_s | aux_uv_s) & ref_armed_s
                                     & ~prot_masked;
        fault_set[`FLT_CORE_SDISC] = core_sd_s & ~prot_masked;
        fault_set[`FLT_AUX_SDISC]  = aux_sd_s & serial & ~prot_masked;
        fault_set[`FLT_CORE_GND]   = core_gnd_s & ~prot_masked;
        fault_set[`FLT_AUX_GND]    = aux_gnd_s & serial & ~prot_masked;
        fault_set[`FLT_CORE_OC]    = core_ocp_s | core_oca_s;
        fault_set[`FLT_AUX_OC]     = aux_oc_s;
    end

    // Fault latches: no soft-start gating, no software clear path
    always @(posedge aclk)
    begin
        if (!aresetn)
            fault_q <= {`FLT_W{1'b0}};
        else if (!en_s)
            fault_q <= {`FLT_W{1'b0}};
        else
            fault_q <= fault_q | fault_set;
    end

    // Anything but overvoltage tristates both rails
    wire hiz_latch = |fault_q[`FLT_AUX_OC:`FLT_UV];
    wire any_fault = |fault_q;

    // First pulse ends the start-up tristate
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_started_q <= 1'b0;
            aux_started_q  <= 1'b0;
        end
        else if (!en_s)
        begin
            core_started_q <= 1'b0;
            aux_started_q  <= 1'b0;
        end
        else
        begin
            core_started_q <= core_started_q | core_first_pulse;
            aux_started_q  <= aux_started_q | aux_first_pulse;
        end
    end

    wire core_hiz = ~en_s | hiz_latch | ~core_started_q
                    | (fault_q[`FLT_AUX_OV] & serial);
    wire aux_hiz  = ~en_s | hiz_latch | ~aux_started_q
                    | (fault_q[`FLT_CORE_OV] & serial);
    wire [2:0] core_st = rail_state(fault_q[`FLT_CORE_OV], core_hiz);
    wire [2:0] aux_st  = rail_state(fault_q[`FLT_AUX_OV], aux_hiz);

    // Driver pins; clamp keeps low-side switches on
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_phase_pwm_out <= {CORE_PHASES{1'b0}};
            core_phase_pwm_oe  <= {CORE_PHASES{1'b0}};
            core_driver_enable <= 1'b0;
            aux_phase_pwm_out  <= 1'b0;
            aux_phase_pwm_oe   <= 1'b0;
            aux_driver_enable  <= 1'b0;
        end
        else
        begin
            case (core_st)
                RAIL_LOW:
                begin
                    core_phase_pwm_out <= {CORE_PHASES{1'b0}};
                    core_phase_pwm_oe  <= {CORE_PHASES{1'b1}};
                    core_driver_enable <= 1'b1;
                end
                RAIL_SWITCH:
                begin
                    core_phase_pwm_out <= core_pwm_in;
                    core_phase_pwm_oe  <= {CORE_PHASES{1'b1}};
                    core_driver_enable <= 1'b1;
                end
                default:
                begin
                    core_phase_pwm_out <= {CORE_PHASES{1'b0}};
                    core_phase_pwm_oe  <= {CORE_PHASES{1'b0}};
                    core_driver_enable <= 1'b0;
                end
            endcase
            case (aux_st)
                RAIL_LOW:
                begin
                    aux_phase_pwm_out <= 1'b0;
                    aux_phase_pwm_oe  <= 1'b1;
                    aux_driver_enable <= 1'b1;
                end
                RAIL_SWITCH:
                begin
                    aux_phase_pwm_out <= aux_pwm_in;
                    aux_phase_pwm_oe  <= 1'b1;
                    aux_driver_enable <= 1'b1;
                end
                default:
                begin
                    aux_phase_pwm_out <= 1'b0;
                    aux_phase_pwm_oe  <= 1'b0;
                    aux_driver_enable <= 1'b0;
                end
            endcase
        end
    end

    // Power good: low-side flags only, rails untouched by it
    wire core_good = ~core_low_s;
    wire aux_good  = ~aux_low_s;
    wire pg_eval   = serial ? (core_good & aux_good) : core_good;
    wire pg_masked = prot_masked | (serial & core_off & aux_started_q);

    // Masked evaluation holds the last verdict
    always @(posedge aclk)
    begin
        if (!aresetn)
            pg_q <= 1'b0;
        else if (!en_s || !soft_start_done || any_fault)
            pg_q <= 1'b0;
        else if (!pg_masked)
            pg_q <= pg_eval;
    end

    // Open-drain power good and fault/threshold pins
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_good_out <= 1'b0;
            power_good_oe  <= 1'b1;
            osc_fault_pin  <= 1'b0;
            ov_thresh_sel  <= `OVSEL_REF_OFFSET;
            ov_offset_mv   <= `OV_OFFSET_RST;
        end
        else
        begin
            power_good_out <= 1'b0;
            power_good_oe  <= ~pg_q;
            osc_fault_pin  <= any_fault;
            ov_offset_mv   <= ov_offset_q;
            if (strap_s)
                ov_thresh_sel <= `OVSEL_PIN;
            else if (mode == `MODE_FIXED)
                ov_thresh_sel <= `OVSEL_FIXED_1V8;
            else
                ov_thresh_sel <= `OVSEL_REF_OFFSET;
        end
    end

    // AXI write: address and data in either order
    wire [3:0] w_hit   = reg_hit(awaddr_q);
    wire [31:0] ov_merged = merge({22'h0, ov_offset_q}, wdata_q, wstrb_q);
    wire       do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= {ADDR_W{1'b0}};
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            ctrl_q        <= `CTRL_RST;
            ov_offset_q   <= `OV_OFFSET_RST;
        end
        else
        begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (w_hit == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
                if (w_hit[0])
                    ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0007;
                if (w_hit[2])
                    ov_offset_q <= ov_merged[`OV_OFFSET_W-1:0];
                // Status and fault words are read-only: writes cannot clear
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read word assembly
    reg [31:0] rword;
    always @*
    begin
        rword = 32'h0000_0000;
        case (reg_hit(s_axi_araddr))
            4'h1: rword = ctrl_q;
            4'h2:
            begin
                rword[`ST_RAIL_GOOD_FLAG]        = pg_q;
                rword[`ST_CORE_GOOD]    = core_good;
                rword[`ST_AUX_GOOD]     = aux_good;
                rword[`ST_PG_MASKED]    = pg_masked;
                rword[`ST_PROT_MASKED]  = prot_masked;
                rword[`ST_ENABLE]       = en_s;
                rword[`ST_STRAP]        = strap_s;
                rword[`ST_CORE_STARTED] = core_started_q;
                rword[`ST_AUX_STARTED]  = aux_started_q;
            end
            4'h4: rword[`OV_OFFSET_W-1:0] = ov_offset_q;
            4'h8: rword[`FLT_W-1:0] = fault_q;
            default: rword = 32'h0000_0000;
        endcase
    end

    // AXI read: answer the cycle after the address
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rword;
                s_axi_rresp  <= (reg_hit(s_axi_araddr) == 4'h0) ?
                                `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // rail_fault_supervisor

// [src/rearm_timer.v]
// Mask: high in a transition and a fixed count of clocks after.
// Assumes transition is synchronous.
`include "rail_fault_defines.vh"
module rearm_timer #(
    parameter CYCLES = `REARM_CYCLES
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire transition,
    output wire masked
);
    localparam [5:0] LOAD = CYCLES;

    reg [5:0] count_q;

    // Reload while moving, count down once settled
    always @(posedge aclk)
    begin
        if (!aresetn)
            count_q <= 6'h00;
        else if (transition)
            count_q <= LOAD;
        else if (count_q != 6'h00)
            count_q <= count_q - 6'h01;
    end

    assign masked = transition | (count_q != 6'h00);
endmodule // rearm_timer
